// [logic/spa_params.svh]
// Register offsets, field positions, reset values and timing counts for the setpoint alarm output block.
`ifndef SPA_PARAMS_SVH
`define SPA_PARAMS_SVH
`define SPA_OFS_CTRL 4'h0
`define SPA_OFS_SETPOINT 4'h4
`define SPA_OFS_HYST 4'h8
`define SPA_OFS_DELAY 4'hC
`define SPA_OFS_FORMAT 6'h20
`define SPA_OFS_STATUS 6'h24
`define SPA_CH_AREA_END 6'h20
`define SPA_CTRL_EN 0
`define SPA_CTRL_ACT_LSB 1
`define SPA_CTRL_MODE_LSB 3
`define SPA_CTRL_DISP 5
`define SPA_CTRL_STBY 6
`define SPA_CTRL_PROBE 7
`define SPA_DLY_OFF_LSB 16
`define SPA_CTRL_RST 8'h00
`define SPA_SP_RST 18'h00000
`define SPA_HY_RST 17'h00000
`define SPA_DLY_RST 13'h0000
`define SPA_FMT_RST 3'h0
`define SPA_SP_MIN (-19999)
`define SPA_SP_MAX 99999
`define SPA_DLY_MAX_TENTHS 13'h176F
`define SPA_CLK_HZ 25000000
`define SPA_TICK_MS 100
`define SPA_TICK_CYCLES ((`SPA_CLK_HZ / 1000) * `SPA_TICK_MS)
`endif

// [logic/spa_pkg.sv]
// Types shared by the setpoint alarm output block.
package spa_pkg;
   typedef enum logic [1:0] {
      SPA_HIGH_ACT_BALANCED,
      SPA_LOW_ACT_BALANCED,
      SPA_HIGH_ACT_UNBALANCED,
      SPA_LOW_ACT_UNBALANCED
   } spa_action_t;
   typedef enum logic [1:0] {
      SPA_AUTO_CLEAR,
      SPA_LATCH_IMMEDIATE_CLEAR,
      SPA_LATCH_DEFERRED_CLEAR
   } spa_mode_t;
endpackage

// [logic/spa_top.sv]
// Two-channel setpoint alarm output logic with an Avalon-MM register slave.
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`include "spa_params.svh"

module spa_top #(
   parameter int NUM_CH = 2,
   parameter int TICK_CYCLES = `SPA_TICK_CYCLES
) (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic [5:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic signed [17:0] DISPLAY_VALUE,
   input wire logic PROBE_FAIL,
   input wire logic KEY_RESET,
   input wire logic USER_RESET,
   input wire logic KEY_TO_DISPLAY,
   input wire logic USER_TO_DISPLAY,
   input wire logic INPUT_SHOWN,
   output logic [1:0] RELAY_OUT
);

   // Configuration registers, one set per channel except the shared format register.
   logic [7:0] ctrl_reg [NUM_CH];
   logic [7:0] ctrl_next [NUM_CH];
   logic signed [17:0] sp_reg [NUM_CH];
   logic signed [17:0] sp_next [NUM_CH];
   logic [16:0] hy_reg [NUM_CH];
   logic [16:0] hy_next [NUM_CH];
   logic [12:0] don_reg [NUM_CH];
   logic [12:0] don_next [NUM_CH];
   logic [12:0] doff_reg [NUM_CH];
   logic [12:0] doff_next [NUM_CH];
   logic [2:0] fmt_reg;
   logic [2:0] fmt_next;
   logic wait_reg;
   logic wait_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   // Channel run state.
   logic [NUM_CH-1:0] out_reg;
   logic [NUM_CH-1:0] out_next;
   logic [NUM_CH-1:0] dem_reg;
   logic [NUM_CH-1:0] dem_next;
   logic [NUM_CH-1:0] blk_reg;
   logic [NUM_CH-1:0] blk_next;
   logic [NUM_CH-1:0] pend_reg;
   logic [NUM_CH-1:0] pend_next;
   logic [NUM_CH-1:0] stby_reg;
   logic [NUM_CH-1:0] stby_next;
   logic [12:0] tmr_reg [NUM_CH];
   logic [12:0] tmr_next [NUM_CH];
   logic [31:0] pre_reg;
   logic [31:0] pre_next;
   logic [1:0] relay_reg;
   logic [1:0] relay_next;
   logic tick;
   logic [NUM_CH-1:0] rst_evt;
   logic [NUM_CH-1:0] want;

   // Merges write data into an old word under the byte enables.
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Clamps a written delay to the longest programmable value of 599.9 s.
   function automatic logic [12:0] dly_clamp(input logic [12:0] d);
      return (d > `SPA_DLY_MAX_TENTHS) ? `SPA_DLY_MAX_TENTHS : d;
   endfunction

   // Clamps a written setpoint into the accepted signed range.
   function automatic logic signed [17:0] sp_clamp(input logic [17:0] d);
      logic signed [17:0] s;
      s = $signed(d);
      if (s < 18'(`SPA_SP_MIN)) begin
         return 18'(`SPA_SP_MIN);
      end else if (s > 18'(`SPA_SP_MAX)) begin
         return 18'(`SPA_SP_MAX);
      end
      return s;
   endfunction

   // Returns {on_cond, off_cond} for one channel; the band is in display counts, so no scaling is needed.
   function automatic logic [1:0] trig(input spa_pkg::spa_action_t act, input logic signed [17:0] v,
                                       input logic signed [17:0] sp, input logic [16:0] h);
      logic signed [19:0] ve;
      logic signed [19:0] se;
      logic signed [19:0] he;
      logic signed [19:0] hh;
      logic on_c;
      logic off_c;
      ve = {{2{v[17]}}, v};
      se = {{2{sp[17]}}, sp};
      he = {3'h0, h};
      hh = {4'h0, h[16:1]};
      case (act)
         spa_pkg::SPA_HIGH_ACT_BALANCED: begin
            on_c = ve >= se + hh;
            off_c = ve <= se - hh;
         end
         spa_pkg::SPA_LOW_ACT_BALANCED: begin
            on_c = ve <= se - hh;
            off_c = ve >= se + hh;
         end
         spa_pkg::SPA_HIGH_ACT_UNBALANCED: begin
            on_c = ve >= se;
            off_c = ve <= se - he;
         end
         default: begin
            on_c = ve <= se;
            off_c = ve >= se + he;
         end
      endcase
      return {on_c, off_c};
   endfunction

   // Bus slave: a request is answered one cycle after it is seen, so waitrequest can come from a flop.
   always_comb begin
      logic [31:0] cur;
      logic [31:0] wd;
      int ch;
      cur = 32'h0000_0000;
      wd = 32'h0000_0000;
      ch = int'(AVS_ADDRESS[4]);
      ctrl_next = ctrl_reg;
      sp_next = sp_reg;
      hy_next = hy_reg;
      don_next = don_reg;
      doff_next = doff_reg;
      fmt_next = fmt_reg;
      wait_next = 1'b1;
      rdata_next = rdata_reg;
      if (AVS_ADDRESS < `SPA_CH_AREA_END) begin
         case ({AVS_ADDRESS[3:2], 2'b00})
            `SPA_OFS_CTRL: cur = {24'h00_0000, ctrl_reg[ch]};
            `SPA_OFS_SETPOINT: cur = {{14{sp_reg[ch][17]}}, sp_reg[ch]};
            `SPA_OFS_HYST: cur = {15'h0000, hy_reg[ch]};
            default: cur = {3'h0, doff_reg[ch], 3'h0, don_reg[ch]};
         endcase
      end else if ({AVS_ADDRESS[5:2], 2'b00} == `SPA_OFS_FORMAT) begin
         cur = {29'h0000_0000, fmt_reg};
      end else if ({AVS_ADDRESS[5:2], 2'b00} == `SPA_OFS_STATUS) begin
         cur = {22'h00_0000, relay_reg, pend_reg, stby_reg, dem_reg, out_reg};
      end
      if ((AVS_READ || AVS_WRITE) && wait_reg) begin
         wait_next = 1'b0;
         rdata_next = AVS_READ ? cur : 32'h0000_0000;
      end
      wd = be_merge(cur, AVS_WRITEDATA, AVS_BYTEENABLE);
      if (AVS_WRITE && !wait_reg) begin
         if (AVS_ADDRESS < `SPA_CH_AREA_END) begin
            case ({AVS_ADDRESS[3:2], 2'b00})
               `SPA_OFS_CTRL: ctrl_next[ch] = wd[7:0];
               `SPA_OFS_SETPOINT: sp_next[ch] = sp_clamp(wd[17:0]);
               `SPA_OFS_HYST: hy_next[ch] = wd[16:0];
               default: begin
                  don_next[ch] = dly_clamp(wd[12:0]);
                  doff_next[ch] = dly_clamp(wd[`SPA_DLY_OFF_LSB +: 13]);
               end
            endcase
         end else if ({AVS_ADDRESS[5:2], 2'b00} == `SPA_OFS_FORMAT) begin
            fmt_next = wd[2:0];
         end
      end
   end

   // Registers of the bus slave and the configuration.
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < NUM_CH; i++) begin
            ctrl_reg[i] <= `SPA_CTRL_RST;
            sp_reg[i] <= `SPA_SP_RST;
            hy_reg[i] <= `SPA_HY_RST;
            don_reg[i] <= `SPA_DLY_RST;
            doff_reg[i] <= `SPA_DLY_RST;
         end
         fmt_reg <= `SPA_FMT_RST;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ctrl_reg <= ctrl_next;
         sp_reg <= sp_next;
         hy_reg <= hy_next;
         don_reg <= don_next;
         doff_reg <= doff_next;
         fmt_reg <= fmt_next;
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
      end
   end

   assign AVS_WAITREQUEST = wait_reg;
   assign AVS_READDATA = rdata_reg;
   assign RELAY_OUT = relay_reg;

   // Channel logic; the tenth-second prescaler is shared so both channels tick together.
   always_comb begin
      spa_pkg::spa_action_t act;
      spa_pkg::spa_mode_t mode;
      logic [1:0] tr;
      logic en;
      logic inhibit;
      logic pend_eff;
      logic manual;
      logic disp;
      logic stby_on;
      act = spa_pkg::SPA_HIGH_ACT_BALANCED;
      mode = spa_pkg::SPA_AUTO_CLEAR;
      tr = 2'b00;
      en = 1'b0;
      inhibit = 1'b0;
      pend_eff = 1'b0;
      stby_on = 1'b0;
      tick = pre_reg == 32'(TICK_CYCLES - 1);
      pre_next = tick ? 32'h0000_0000 : pre_reg + 32'h0000_0001;
      manual = (KEY_RESET && !KEY_TO_DISPLAY) || (USER_RESET && !USER_TO_DISPLAY);
      disp = INPUT_SHOWN && ((KEY_RESET && KEY_TO_DISPLAY) || (USER_RESET && USER_TO_DISPLAY));
      for (int i = 0; i < NUM_CH; i++) begin
         act = spa_pkg::spa_action_t'(ctrl_reg[i][`SPA_CTRL_ACT_LSB +: 2]);
         mode = spa_pkg::spa_mode_t'(ctrl_reg[i][`SPA_CTRL_MODE_LSB +: 2]);
         en = ctrl_reg[i][`SPA_CTRL_EN];
         tr = trig(act, DISPLAY_VALUE, sp_reg[i], hy_reg[i]);
         rst_evt[i] = manual || (disp && ctrl_reg[i][`SPA_CTRL_DISP]);
         dem_next[i] = tr[1] ? 1'b1 : (tr[0] ? 1'b0 : dem_reg[i]);
         // Standby runs from reset until an enabled channel sees the value off its on side, or its output is on.
         // It is kept while the channel is disabled, because the settings can only be written after reset ends.
         stby_next[i] = stby_reg[i] && !out_reg[i] && (!en || tr[1]);
         stby_on = stby_next[i] && ctrl_reg[i][`SPA_CTRL_STBY];
         blk_next[i] = (blk_reg[i] || (rst_evt[i] && mode != spa_pkg::SPA_LATCH_DEFERRED_CLEAR))
                       && dem_next[i];
         inhibit = blk_next[i] || stby_on;
         pend_eff = pend_reg[i] || rst_evt[i];
         case (mode)
            spa_pkg::SPA_LATCH_IMMEDIATE_CLEAR: want[i] = (dem_next[i] || out_reg[i]) && !inhibit;
            spa_pkg::SPA_LATCH_DEFERRED_CLEAR: begin
               want[i] = (dem_next[i] || (out_reg[i] && !pend_eff)) && !stby_on;
            end
            default: want[i] = dem_next[i] && !inhibit;
         endcase
         out_next[i] = out_reg[i];
         tmr_next[i] = tmr_reg[i];
         if (!en) begin
            out_next[i] = 1'b0;
            tmr_next[i] = 13'h0000;
            blk_next[i] = 1'b0;
         end else if (rst_evt[i] && out_reg[i] && mode != spa_pkg::SPA_LATCH_DEFERRED_CLEAR) begin
            out_next[i] = 1'b0;
            tmr_next[i] = 13'h0000;
         end else if (want[i] == out_reg[i]) begin
            tmr_next[i] = 13'h0000;
         end else if (tmr_reg[i] >= (want[i] ? don_reg[i] : doff_reg[i])) begin
            out_next[i] = want[i];
            tmr_next[i] = 13'h0000;
         end else if (tick) begin
            tmr_next[i] = tmr_reg[i] + 13'h0001;
         end
         pend_next[i] = en && mode == spa_pkg::SPA_LATCH_DEFERRED_CLEAR && pend_eff && out_next[i];
         relay_next[i] = en && (PROBE_FAIL ? ctrl_reg[i][`SPA_CTRL_PROBE] : out_next[i]);
      end
   end

   // Run state registers; reset brings every output up off and drops any pending clear.
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         out_reg <= '0;
         dem_reg <= '0;
         blk_reg <= '0;
         pend_reg <= '0;
         stby_reg <= '1;
         for (int i = 0; i < NUM_CH; i++) begin
            tmr_reg[i] <= 13'h0000;
         end
         pre_reg <= 32'h0000_0000;
         relay_reg <= 2'b00;
      end else begin
         out_reg <= out_next;
         dem_reg <= dem_next;
         blk_reg <= blk_next;
         pend_reg <= pend_next;
         stby_reg <= stby_next;
         tmr_reg <= tmr_next;
         pre_reg <= pre_next;
         relay_reg <= relay_next;
      end
   end

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RSTN);

   // A bus request stalls one cycle and is then answered.
   sequence s_req_waiting;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   endsequence

   chk_bus_answer: assert property (s_req_waiting |=> !AVS_WAITREQUEST)
      else $error("bus request not answered after one wait cycle");

   // Checks repeated for each channel.
   for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
      sequence s_turn_on;
         !out_reg[g] ##1 out_reg[g];
      endsequence

      // Turning off is the mirror step; only the off delay, a reset event or disabling may cause it.
      sequence s_turn_off;
         out_reg[g] ##1 !out_reg[g];
      endsequence

      chk_disabled_off: assert property (!ctrl_reg[g][`SPA_CTRL_EN] |=> !RELAY_OUT[g])
         else $error("disabled channel drives its relay");
      chk_probe_force: assert property (PROBE_FAIL && ctrl_reg[g][`SPA_CTRL_EN]
         |=> RELAY_OUT[g] == $past(ctrl_reg[g][`SPA_CTRL_PROBE]))
         else $error("probe failure state not forced");
      chk_manual_clear: assert property (out_reg[g] && rst_evt[g] && ctrl_reg[g][`SPA_CTRL_EN]
         && ctrl_reg[g][`SPA_CTRL_MODE_LSB +: 2] != 2'h2 |=> !out_reg[g])
         else $error("manual reset did not clear output at once");
      chk_deferred_hold: assert property (out_reg[g] && dem_next[g] && ctrl_reg[g][`SPA_CTRL_EN]
         && ctrl_reg[g][`SPA_CTRL_MODE_LSB +: 2] == 2'h2 |=> out_reg[g])
         else $error("deferred latch cleared before off trigger");
      chk_latch_hold: assert property (out_reg[g] && !rst_evt[g] && ctrl_reg[g][`SPA_CTRL_EN]
         && ctrl_reg[g][`SPA_CTRL_MODE_LSB +: 2] == 2'h1 |=> out_reg[g])
         else $error("immediate latch released without reset");
      chk_zero_delay: assert property (ctrl_reg[g][`SPA_CTRL_EN] && want[g] && !out_reg[g]
         && don_reg[g] == 13'h0000 |=> out_reg[g])
         else $error("zero on delay did not switch at once");
      chk_on_delay: assert property (s_turn_on |-> $past(tmr_reg[g]) >= $past(don_reg[g]))
         else $error("output turned on before on delay elapsed");
      chk_off_delay: assert property (s_turn_off |-> $past(tmr_reg[g]) >= $past(doff_reg[g])
         || $past(rst_evt[g]) || !$past(ctrl_reg[g][`SPA_CTRL_EN]))
         else $error("output turned off before off delay elapsed");
      // Standby must hold the output off whatever the value does meanwhile.
      chk_standby_hold: assert property (stby_next[g] && ctrl_reg[g][`SPA_CTRL_STBY] |=> !out_reg[g])
         else $error("output turned on during standby");
      chk_display_gate: assert property (KEY_RESET && KEY_TO_DISPLAY && !INPUT_SHOWN && !USER_RESET
         && out_reg[g] && dem_next[g] && ctrl_reg[g][`SPA_CTRL_EN]
         && ctrl_reg[g][`SPA_CTRL_MODE_LSB +: 2] == 2'h1 |=> out_reg[g])
         else $error("display reset cleared output while input hidden");
   end

endmodule

// [tb/spa_partner.sv]
// Front panel reset sources and relay sink that face the setpoint alarm output block.
`timescale 1ns/100ps
module spa_partner (
   input wire logic clk,
   input wire logic [1:0] relay_out,
   output logic key_reset,
   output logic user_reset,
   output logic key_to_display,
   output logic user_to_display,
   output logic input_shown
);
   // Buttons start released and both sources start on plain output reset.
   initial begin
      key_reset = 1'b0;
      user_reset = 1'b0;
      key_to_display = 1'b0;
      user_to_display = 1'b0;
      input_shown = 1'b0;
   end

   // A press lasts one clock, because every high cycle counts as a separate reset event.
   task automatic press(input logic from_user);
      @(posedge clk);
      if (from_user) user_reset <= 1'b1;
      else key_reset <= 1'b1;
      @(posedge clk);
      user_reset <= 1'b0;
      key_reset <= 1'b0;
   endtask

   // Display reset only reaches the relays when the source is assigned to it and the value is shown.
   task automatic route(input logic to_disp, input logic shown);
      @(posedge clk);
      key_to_display <= to_disp;
      user_to_display <= to_disp;
      input_shown <= shown;
   endtask
endmodule

// [tb/spa_top_tb.sv]
// Self-checking bench for the two-channel setpoint alarm output block.
`timescale 1ns/100ps
`include "spa_params.svh"
module spa_top_tb;
   logic clk, rstn, av_read, av_write, wait_req, probe_fail;
   logic [5:0] av_addr;
   logic [31:0] av_wdata, av_rdata, rd;
   logic signed [17:0] disp_val;
   logic [1:0] relay;
   logic key_rst, user_rst, key_disp, user_disp, shown;
   int failures, samples_checked;
   int seq [4][4] = '{'{80, 105, 96, 95}, '{120, 95, 104, 105}, '{80, 100, 91, 90}, '{120, 100, 109, 110}};

   // A four-cycle tick keeps the tenth-of-a-second timers short in simulation.
   spa_top #(.NUM_CH(2), .TICK_CYCLES(4)) i_spa_top (
      .CORE_CLK(clk), .RSTN(rstn), .AVS_ADDRESS(av_addr), .AVS_READ(av_read), .AVS_WRITE(av_write),
      .AVS_WRITEDATA(av_wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(wait_req),
      .DISPLAY_VALUE(disp_val), .PROBE_FAIL(probe_fail), .KEY_RESET(key_rst), .USER_RESET(user_rst),
      .KEY_TO_DISPLAY(key_disp), .USER_TO_DISPLAY(user_disp), .INPUT_SHOWN(shown), .RELAY_OUT(relay));
   spa_partner i_spa_partner (
      .clk(clk), .relay_out(relay), .key_reset(key_rst), .user_reset(user_rst),
      .key_to_display(key_disp), .user_to_display(user_disp), .input_shown(shown));

   // The 25 MHz core clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic give_verdict();
      $display("Checks made: %0d, mismatches: %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic mismatch(input string msg);
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
   endtask

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) mismatch($sformatf("register read %h, expected %h", got, exp));
   endtask

   task automatic chk_relay(input logic [1:0] exp);
      samples_checked++;
      if (relay !== exp) mismatch($sformatf("relay %b, expected %b", relay, exp));
   endtask

   function automatic logic [5:0] ra(input int ch, input logic [3:0] ofs);
      return 6'(ch * 16) + 6'(ofs);
   endfunction

   // One Avalon access; the request stands until waitrequest is sampled low.
   task automatic bus(input logic is_wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      av_addr <= a;
      av_wdata <= d;
      av_write <= is_wr;
      av_read <= ~is_wr;
      do begin
         @(posedge clk);
         n++;
      end while (wait_req !== 1'b0 && n < 100);
      rd = av_rdata;
      av_write <= 1'b0;
      av_read <= 1'b0;
      if (n >= 100) begin
         mismatch("bus answer never came");
         give_verdict();
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rc(input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk_reg(rd, exp);
   endtask

   // With zero delay the relay follows one cycle later, so three cycles is ample settling.
   task automatic apply(input int v, input logic [1:0] exp);
      @(posedge clk);
      disp_val <= 18'(v);
      repeat (3) @(posedge clk);
      chk_relay(exp);
   endtask

   task automatic press_chk(input logic from_user, input logic [1:0] exp);
      i_spa_partner.press(from_user);
      repeat (3) @(posedge clk);
      chk_relay(exp);
   endtask

   // The timer tick jitters by one tick, so the window allows a tick either way.
   task automatic wait_relay(input logic [1:0] exp, input int lo, input int hi);
      int n;
      n = 0;
      while (relay !== exp && n <= hi) begin
         @(posedge clk);
         n++;
      end
      samples_checked++;
      if (n < lo || n > hi) mismatch($sformatf("relay took %0d cycles, window %0d to %0d", n, lo, hi));
   endtask

   // Main sequence.
   initial begin
      rstn = 1'b0;
      av_read = 1'b0;
      av_write = 1'b0;
      av_addr = 6'h00;
      av_wdata = 32'h0;
      disp_val = 18'sh64;
      probe_fail = 1'b0;
      failures = 0;
      samples_checked = 0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rc(ra(0, `SPA_OFS_CTRL), 32'h0);
      rc(ra(1, `SPA_OFS_DELAY), 32'h0);
      rc(6'h28, 32'h0);
      // Standby on the second channel; the value sits on the on side from reset.
      wr(ra(1, `SPA_OFS_SETPOINT), 32'h64);
      wr(ra(1, `SPA_OFS_HYST), 32'hA);
      wr(ra(1, `SPA_OFS_CTRL), 32'h45);
      apply(100, 2'b00);
      apply(80, 2'b00);
      apply(100, 2'b10);
      wr(ra(1, `SPA_OFS_CTRL), 32'h0);
      apply(100, 2'b00);
      $display("Test standby done");
      wr(ra(1, `SPA_OFS_SETPOINT), 32'h0001D4C0);
      rc(ra(1, `SPA_OFS_SETPOINT), 32'h0001869F);
      wr(ra(1, `SPA_OFS_SETPOINT), 32'hFFFF8AD0);
      rc(ra(1, `SPA_OFS_SETPOINT), 32'hFFFFB1E1);
      wr(`SPA_OFS_FORMAT, 32'h3);
      rc(`SPA_OFS_FORMAT, 32'h3);
      $display("Test setpoint range done");
      // All four actions, each started from a clearly off value.
      wr(ra(0, `SPA_OFS_SETPOINT), 32'h64);
      wr(ra(0, `SPA_OFS_HYST), 32'hA);
      for (int a = 0; a < 4; a++) begin
         wr(ra(0, `SPA_OFS_CTRL), 32'h0);
         apply(seq[a][0], 2'b00);
         wr(ra(0, `SPA_OFS_CTRL), 32'(a * 2 + 1));
         for (int s = 1; s < 4; s++) apply(seq[a][s], (s < 3) ? 2'b01 : 2'b00);
      end
      $display("Test actions done");
      // On delay of three tenths, off delay of two, with an aborted start first.
      wr(ra(0, `SPA_OFS_CTRL), 32'h5);
      apply(80, 2'b00);
      wr(ra(0, `SPA_OFS_DELAY), 32'h00020003);
      @(posedge clk) disp_val <= 18'sh64;
      repeat (5) @(posedge clk);
      disp_val <= 18'sh50;
      repeat (10) @(posedge clk);
      chk_relay(2'b00);
      disp_val <= 18'sh64;
      wait_relay(2'b01, 8, 19);
      @(posedge clk) disp_val <= 18'sh5A;
      wait_relay(2'b00, 4, 15);
      wr(ra(0, `SPA_OFS_DELAY), 32'h0);
      $display("Test delays done");
      apply(100, 2'b01);
      press_chk(1'b0, 2'b00);
      apply(100, 2'b00);
      apply(90, 2'b00);
      apply(100, 2'b01);
      wr(ra(0, `SPA_OFS_CTRL), 32'hD);
      apply(80, 2'b01);
      press_chk(1'b1, 2'b00);
      apply(100, 2'b01);
      wr(ra(0, `SPA_OFS_CTRL), 32'h15);
      press_chk(1'b0, 2'b01);
      apply(80, 2'b00);
      apply(100, 2'b01);
      apply(80, 2'b01);
      $display("Test reset modes done");
      wr(ra(0, `SPA_OFS_CTRL), 32'h5);
      apply(100, 2'b01);
      i_spa_partner.route(1'b1, 1'b1);
      press_chk(1'b0, 2'b01);
      // Immediate latch with display reset, so a reset wrongly let through while hidden would show.
      wr(ra(0, `SPA_OFS_CTRL), 32'h2D);
      i_spa_partner.route(1'b1, 1'b0);
      press_chk(1'b0, 2'b01);
      i_spa_partner.route(1'b1, 1'b1);
      press_chk(1'b0, 2'b00);
      i_spa_partner.route(1'b0, 1'b0);
      $display("Test display reset done");
      wr(ra(0, `SPA_OFS_CTRL), 32'h85);
      apply(80, 2'b00);
      @(posedge clk) probe_fail <= 1'b1;
      apply(80, 2'b01);
      wr(ra(0, `SPA_OFS_CTRL), 32'h5);
      apply(100, 2'b00);
      @(posedge clk) probe_fail <= 1'b0;
      apply(100, 2'b01);
      $display("Test probe failure done");
      // A pending deferred clear must not survive a power cycle.
      wr(ra(0, `SPA_OFS_CTRL), 32'h15);
      press_chk(1'b0, 2'b01);
      bus(1'b0, `SPA_OFS_STATUS, 32'h0);
      chk_reg(rd & 32'h00000303, 32'h00000101);
      chk_reg(rd & 32'h000000C0, 32'h00000040);
      @(posedge clk) rstn <= 1'b0;
      disp_val <= 18'sh50;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      chk_relay(2'b00);
      bus(1'b0, `SPA_OFS_STATUS, 32'h0);
      chk_reg(rd & 32'h000000C0, 32'h0);
      $display("Test power cycle done");
      give_verdict();
   end

   // Cut a hang short; the whole run needs far fewer cycles than this.
   initial begin
      repeat (20000) @(posedge clk);
      mismatch("run did not finish");
      give_verdict();
   end
endmodule
